// >>> logic/eeprom_defines.svh
// constants for the two-wire eeprom target and its bus controller
// assumes a 200 MHz system clock on both ends
// Overview of operation
// [RULE1] each start is followed by device address byte
// [RULE2] upper four address bits must match type code
// [RULE3] 11/10-bit capacities fold top bits into address
// [RULE4] 9-bit folds one bit; smaller send zeros
// [RULE5] last address bit: one reads, zero writes
// [RULE6] match acknowledges low; mismatch returns to standby
// [RULE7] write: word address then data, each acknowledged
// [RULE8] controller ends every write with a stop
// [RULE9] stop after write starts timed cycle, ignoring bus
// [RULE10] page is eight or sixteen bytes by capacity
// [RULE11] page write takes 7 or 15 more bytes
// [RULE12] write increments only page bits, wrapping in page
// [RULE13] no acknowledge while write cycle is running
// [RULE14] address counter holds last address plus one
// [RULE15] read counter wraps from end to start
// [RULE16] read address byte shifts out current-address byte
// [RULE17] random read: dummy write, repeated start, read
// [RULE18] controller ack advances counter, sends next byte
// [RULE19] read ends with no-ack then stop; release
// [RULE20] eight data bits, receiver acknowledges ninth clock
// [RULE21] missing read acknowledge returns device to standby
// [RULE22] write cycle is a timer; page commits at expiry
// [RULE23] sample on clock rise, change data while low
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
// arbitrary device type code
`define DEV_TYPE_CODE 4'h6
`define DEF_ADDR_BITS 9
`define MAX_WA_BITS 11
`define SMALL_CAP_BITS 8
`define PAGE_BITS_SMALL 3
`define PAGE_BITS_LARGE 4
`define PAGE_MAX 16
`define ACK_IDX 4'h8
`define TWR_MS 5
`define CLK_MHZ 200
`define TWR_CYCLES (`TWR_MS * 1000 * `CLK_MHZ)
`define SCL_QTR 3'h7
`define PH_DRIVE 2'h0
`define PH_RISE 2'h1
`define PH_SAMPLE 2'h2
`define PH_FALL 2'h3
`define BUF_FULL 2'h2
`endif

// >>> logic/eeprom_pkg.sv
// shared state encodings for both ends of the eeprom link
// assumes eeprom_defines.svh for all numeric constants
package eeprom_pkg;
  typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_RACK, D_BUSY} dev_state_e;
  typedef enum {K_DEV, K_WADDR, K_WDATA} byte_kind_e;
  typedef enum {C_IDLE, C_START, C_DEV, C_WADDR, C_WDATA, C_RSTART, C_RDEV, C_RDATA, C_STOP} ctl_state_e;
endpackage : eeprom_pkg

// >>> logic/eeprom_link_if.sv
// two-wire link between bus controller and eeprom target
// open-drain data: an enable pulls the line low, released line reads high
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : eeprom_link_if

// >>> logic/eeprom_target.sv
// eeprom target: address decode, page write, timed write cycle, reads
// assumes scl and sda arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module eeprom_target #(
  parameter int addr_bits = `DEF_ADDR_BITS,
  parameter int twr_cycles = `TWR_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  eeprom_link_if.dev link,
  output logic write_busy,
  output logic [10:0] word_ptr
);
  localparam int DEPTH = 1 << addr_bits;
  localparam int PBITS = (addr_bits <= `SMALL_CAP_BITS) ? `PAGE_BITS_SMALL : `PAGE_BITS_LARGE;
  localparam logic [10:0] AMASK = 11'(DEPTH - 1);
  localparam logic [10:0] PMASK = 11'((1 << PBITS) - 1);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    eeprom_pkg::dev_state_e st;
    eeprom_pkg::byte_kind_e kind;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic [2:0] hi;
    logic [10:0] cnt;
    logic sda_oe;
    logic wr_pend;
    logic [31:0] tmr;
    logic [10:0] pg_base;
    logic [`PAGE_MAX-1:0] pg_vld;
    logic [`PAGE_MAX-1:0][7:0] pg;
    logic [DEPTH-1:0][7:0] mem;
  } dev_s;

  dev_s r;
  dev_s n;

  // only the page bits step, the row stays put
  function automatic logic [10:0] page_next(input logic [10:0] a);
    page_next = (a & ~PMASK) | ((a + 11'h001) & PMASK);
  endfunction : page_next

  function automatic logic [10:0] array_next(input logic [10:0] a);
    array_next = (a + 11'h001) & AMASK;
  endfunction : array_next

  logic rise;
  logic fall;
  logic start;
  logic stop;
  assign rise = r.scl_s && !r.scl_d;
  assign fall = !r.scl_s && r.scl_d;
  assign start = r.scl_s && r.scl_d && r.sda_d && !r.sda_s;
  assign stop = r.scl_s && r.scl_d && !r.sda_d && r.sda_s;

  always_comb begin
    logic [10:0] idx;
    logic [10:0] a;
    idx = 11'h000;
    a = 11'h000;
    n = r;
    n.scl_m = link.scl;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = link.sda;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;
    if (r.st == eeprom_pkg::D_BUSY) begin
      // bus ignored entirely, so polling sees no acknowledge
      n.sda_oe = 1'b0; // [RULE9] [RULE13]
      n.tmr = r.tmr + 32'h0000_0001; // [RULE22]
      if (r.tmr == 32'(twr_cycles - 1)) begin
        for (int i = 0; i < `PAGE_MAX; i++) begin
          idx = (r.pg_base | 11'(i)) & AMASK;
          if (r.pg_vld[i]) begin
            n.mem[idx[addr_bits-1:0]] = r.pg[i]; // [RULE22]
          end
        end
        n.pg_vld = '0;
        n.st = eeprom_pkg::D_IDLE;
      end
    end else if (start) begin
      n.st = eeprom_pkg::D_RX; // [RULE1]
      n.kind = eeprom_pkg::K_DEV;
      n.bits = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.sda_oe = 1'b0; // [RULE19]
      n.tmr = 32'h0000_0000;
      n.wr_pend = 1'b0;
      n.st = r.wr_pend ? eeprom_pkg::D_BUSY : eeprom_pkg::D_IDLE; // [RULE9]
    end else begin
      unique case (r.st)
        eeprom_pkg::D_IDLE: begin
        end
        eeprom_pkg::D_RX: begin
          if (rise && r.bits != `ACK_IDX) begin
            n.sh = {r.sh[6:0], r.sda_s}; // [RULE23]
            n.bits = r.bits + 4'h1; // [RULE20]
          end else if (fall && r.bits == `ACK_IDX) begin
            n.st = eeprom_pkg::D_ACK;
            n.sda_oe = 1'b1; // [RULE7] [RULE11] [RULE20]
            unique case (r.kind)
              eeprom_pkg::K_DEV: begin
                if (r.sh[7:4] == `DEV_TYPE_CODE) begin // [RULE2]
                  n.rw = r.sh[0]; // [RULE5]
                  if (!r.sh[0]) begin
                    n.hi = r.sh[3:1]; // [RULE3] [RULE4]
                    n.kind = eeprom_pkg::K_WADDR;
                  end
                end else begin
                  n.sda_oe = 1'b0; // [RULE6]
                  n.st = eeprom_pkg::D_IDLE;
                end
              end
              eeprom_pkg::K_WADDR: begin
                // bits above the capacity are masked off
                n.cnt = {r.hi, r.sh} & AMASK; // [RULE3] [RULE4]
                n.kind = eeprom_pkg::K_WDATA;
              end
              eeprom_pkg::K_WDATA: begin
                if (!r.wr_pend) begin
                  n.pg_base = r.cnt & ~PMASK; // [RULE10]
                end
                a = r.cnt & PMASK;
                n.pg[a[3:0]] = r.sh;
                n.pg_vld[a[3:0]] = 1'b1;
                n.cnt = page_next(r.cnt); // [RULE12] [RULE14]
                n.wr_pend = 1'b1;
              end
            endcase
          end
        end
        eeprom_pkg::D_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.bits = 4'h0;
            if (r.kind == eeprom_pkg::K_DEV && r.rw) begin
              // read: shift out current address without a word address
              n.sh = {r.mem[r.cnt[addr_bits-1:0]][6:0], 1'b0}; // [RULE16]
              n.sda_oe = !r.mem[r.cnt[addr_bits-1:0]][7]; // [RULE23]
              n.cnt = array_next(r.cnt); // [RULE14] [RULE15] [RULE18]
              n.bits = 4'h1;
              n.st = eeprom_pkg::D_TX;
            end else begin
              n.st = eeprom_pkg::D_RX;
            end
          end
        end
        eeprom_pkg::D_TX: begin
          if (fall) begin
            if (r.bits == `ACK_IDX) begin
              n.sda_oe = 1'b0; // [RULE20]
              n.st = eeprom_pkg::D_RACK;
            end else begin
              n.sda_oe = !r.sh[7]; // [RULE23]
              n.sh = {r.sh[6:0], 1'b0};
              n.bits = r.bits + 4'h1;
            end
          end
        end
        eeprom_pkg::D_RACK: begin
          if (rise) begin
            // an acknowledge reuses the ack state to load the next byte
            n.st = r.sda_s ? eeprom_pkg::D_IDLE : eeprom_pkg::D_ACK; // [RULE18] [RULE19] [RULE21]
          end
        end
        eeprom_pkg::D_BUSY: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = r.sda_oe;
  assign write_busy = (r.st == eeprom_pkg::D_BUSY);
  assign word_ptr = r.cnt;
endmodule : eeprom_target

// >>> logic/eeprom_controller.sv
// bus controller for the eeprom: byte/page writes and random/sequential reads
// assumes the target on the same link; read data drains through a two-entry buffer
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module eeprom_controller #(
  parameter int addr_bits = `DEF_ADDR_BITS
) (
  input wire logic clk,
  input wire logic arst_n,
  eeprom_link_if.ctl link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [10:0] cmd_addr,
  input wire logic [4:0] cmd_len,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic done,
  output logic nack
);
  localparam logic [10:0] AMASK = 11'((1 << addr_bits) - 1);

  typedef struct packed {
    eeprom_pkg::ctl_state_e st;
    logic [2:0] q;
    logic [1:0] ph;
    logic [3:0] bit_i;
    logic [7:0] sh;
    logic scl;
    logic sda_oe;
    logic sda_m;
    logic sda_s;
    logic rd;
    logic [10:0] addr;
    logic [4:0] left;
    logic ack_ok;
    logic err;
    logic done;
    logic [1:0][7:0] fb;
    logic [1:0] fcnt;
    logic wp;
    logic rp;
  } ctl_s;

  ctl_s r;
  ctl_s n;

  // device address byte with folded word bits; zeros above capacity
  function automatic logic [7:0] dev_byte(input logic [10:0] a, input logic rd);
    dev_byte = {`DEV_TYPE_CODE, a[10:8], rd}; // [RULE1] [RULE3] [RULE4] [RULE5]
  endfunction : dev_byte

  logic tick;
  logic tx;
  logic rx;
  logic hold;
  logic push;
  logic pop;
  assign tick = (r.q == `SCL_QTR);
  assign tx = (r.st == eeprom_pkg::C_DEV) || (r.st == eeprom_pkg::C_WADDR) ||
              (r.st == eeprom_pkg::C_WDATA) || (r.st == eeprom_pkg::C_RDEV);
  assign rx = (r.st == eeprom_pkg::C_RDATA);
  // holding scl low stalls the target until the buffer or source catches up
  assign hold = (r.ph == `PH_DRIVE) && (r.bit_i == 4'h0) &&
                (((r.st == eeprom_pkg::C_WDATA) && !wr_valid) || (rx && (r.fcnt == `BUF_FULL)));
  assign wr_ready = tick && (r.st == eeprom_pkg::C_WDATA) && (r.ph == `PH_DRIVE) && (r.bit_i == 4'h0);
  assign push = tick && rx && (r.ph == `PH_FALL) && (r.bit_i == `ACK_IDX);
  assign pop = rd_valid && rd_ready;

  always_comb begin
    n = r;
    n.sda_m = link.sda;
    n.sda_s = r.sda_m;
    n.done = 1'b0;
    if (pop) begin
      n.rp = !r.rp;
    end
    if (push) begin
      n.fb[r.wp] = r.sh;
      n.wp = !r.wp;
    end
    n.fcnt = r.fcnt + {1'b0, push} - {1'b0, pop};
    if (r.st == eeprom_pkg::C_IDLE) begin
      n.scl = 1'b1;
      n.sda_oe = 1'b0;
      n.q = 3'h0;
      n.ph = `PH_DRIVE;
      if (cmd_valid) begin
        n.rd = cmd_read;
        n.addr = cmd_addr & AMASK;
        n.left = (cmd_len == 5'h00) ? 5'h01 : cmd_len;
        n.err = 1'b0;
        n.st = eeprom_pkg::C_START;
      end
    end else if (!tick || hold) begin
      n.q = tick ? r.q : r.q + 3'h1;
    end else begin
      n.q = 3'h0;
      n.ph = r.ph + 2'h1;
      if (r.st == eeprom_pkg::C_START || r.st == eeprom_pkg::C_RSTART) begin
        unique case (r.ph)
          `PH_DRIVE: begin
            n.scl = 1'b0;
            n.sda_oe = 1'b0;
          end
          `PH_RISE: n.scl = 1'b1;
          `PH_SAMPLE: n.sda_oe = 1'b1;
          `PH_FALL: begin
            n.scl = 1'b0;
            n.bit_i = 4'h0;
            n.sh = dev_byte(r.addr, r.st == eeprom_pkg::C_RSTART); // [RULE17]
            n.st = (r.st == eeprom_pkg::C_START) ? eeprom_pkg::C_DEV : eeprom_pkg::C_RDEV;
          end
        endcase
      end else if (r.st == eeprom_pkg::C_STOP) begin
        unique case (r.ph)
          `PH_DRIVE: begin
            n.scl = 1'b0;
            n.sda_oe = 1'b1;
          end
          `PH_RISE: n.scl = 1'b1;
          `PH_SAMPLE: n.sda_oe = 1'b0; // [RULE8] [RULE19]
          `PH_FALL: begin
            n.done = 1'b1;
            n.st = eeprom_pkg::C_IDLE;
          end
        endcase
      end else begin
        unique case (r.ph)
          `PH_DRIVE: begin
            n.scl = 1'b0;
            n.sda_oe = 1'b0;
            if (r.st == eeprom_pkg::C_WDATA && r.bit_i == 4'h0) begin
              n.sh = wr_data;
              n.sda_oe = !wr_data[7];
            end else if (tx && r.bit_i != `ACK_IDX) begin
              n.sda_oe = !r.sh[7];
            end else if (rx && r.bit_i == `ACK_IDX) begin
              n.sda_oe = (r.left != 5'h01); // [RULE18] [RULE19] [RULE20]
            end
          end
          `PH_RISE: n.scl = 1'b1;
          `PH_SAMPLE: begin
            if (rx && r.bit_i != `ACK_IDX) begin
              n.sh = {r.sh[6:0], r.sda_s};
            end
            if (tx && r.bit_i == `ACK_IDX) begin
              n.ack_ok = !r.sda_s; // [RULE6] [RULE7] [RULE13]
            end
          end
          `PH_FALL: begin
            n.scl = 1'b0;
            n.bit_i = r.bit_i + 4'h1;
            if (tx && r.bit_i != `ACK_IDX) begin
              n.sh = {r.sh[6:0], 1'b0};
            end
            if (r.bit_i == `ACK_IDX) begin
              n.bit_i = 4'h0;
              if (tx && !r.ack_ok) begin
                n.err = 1'b1;
                n.st = eeprom_pkg::C_STOP;
              end else begin
                unique case (r.st)
                  eeprom_pkg::C_DEV: begin
                    n.sh = r.addr[7:0]; // [RULE7]
                    n.st = eeprom_pkg::C_WADDR;
                  end
                  eeprom_pkg::C_WADDR: n.st = r.rd ? eeprom_pkg::C_RSTART : eeprom_pkg::C_WDATA; // [RULE17]
                  eeprom_pkg::C_RDEV: n.st = eeprom_pkg::C_RDATA;
                  default: begin
                    // page write or read: count down, stop after the last byte
                    n.left = r.left - 5'h01; // [RULE11]
                    if (r.left == 5'h01) begin
                      n.st = eeprom_pkg::C_STOP; // [RULE8]
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign cmd_ready = (r.st == eeprom_pkg::C_IDLE);
  assign rd_valid = (r.fcnt != 2'h0);
  assign rd_data = r.fb[r.rp];
  assign done = r.done;
  assign nack = r.done && r.err;
  // idle line stays high; scl is low only until the first edge after reset
  assign link.scl = r.scl;
  assign link.ctl_sda_o = 1'b0;
  assign link.ctl_sda_oe = r.sda_oe;
endmodule : eeprom_controller

// >>> verification/eeprom_link_monitor.sv
// link checker: framing, acknowledge slots and write-cycle quiet time
// assumes it sits beside the link interface, fed the raw link signals
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module eeprom_link_monitor #(
  parameter int twr_cycles = 600
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic write_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic scl_q, sda_q, rd_m, wr_m, busy_s;
  logic [3:0] bit_r;
  logic [4:0] byte_r;
  logic [7:0] sh_r;
  int busy_len;
  wire rise = scl && !scl_q;
  wire fall = !scl && scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b0;
      sda_q <= 1'b1;
      rd_m <= 1'b0;
      wr_m <= 1'b0;
      busy_s <= 1'b0;
      bit_r <= 4'h0;
      byte_r <= 5'h00;
      sh_r <= 8'h00;
      busy_len <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      busy_len <= write_busy ? busy_len + 1 : 0;
      if (start || stop) begin
        bit_r <= 4'h0;
        byte_r <= 5'h00;
        rd_m <= 1'b0;
        wr_m <= 1'b0;
        busy_s <= write_busy;
      end else if (rise) begin
        bit_r <= (bit_r == `ACK_IDX) ? 4'h0 : bit_r + 4'h1;
        if (bit_r != `ACK_IDX) sh_r <= {sh_r[6:0], sda};
        if (bit_r == `ACK_IDX) byte_r <= byte_r + 5'h01;
        if (bit_r == `ACK_IDX && byte_r == 5'h00) begin
          rd_m <= sh_r[0] && !sda;
          wr_m <= !sh_r[0] && !sda;
        end
      end
    end
  end
  // acknowledge slot of the address byte, then of any later byte of an acknowledged write
  sequence addr_slot;
    rise && bit_r == `ACK_IDX && byte_r == 5'h00;
  endsequence
  sequence data_slot;
    rise && bit_r == `ACK_IDX && byte_r != 5'h00 && wr_m;
  endsequence
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  chk_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  chk_dev_edge_low: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("target changed sda while scl high");
  chk_busy_quiet: assert property (write_busy |-> !dev_sda_oe)
    else $error("target drove sda during write cycle");
  chk_busy_length: assert property ($fell(write_busy) |-> busy_len >= twr_cycles - 1 && busy_len <= twr_cycles + 1)
    else $error("write cycle length wrong");
  chk_addr_ack: assert property (addr_slot |-> sda == !(sh_r[7:4] == `DEV_TYPE_CODE && !busy_s))
    else $error("address acknowledge wrong");
  chk_write_ack: assert property (data_slot |-> !sda)
    else $error("write byte not acknowledged");
  chk_read_release: assert property (fall && rd_m && byte_r != 5'h00 && bit_r != 4'h0 |-> !ctl_sda_oe)
    else $error("controller drove sda in read data");
  chk_rdack_release: assert property (fall && rd_m && byte_r > 5'h01 && bit_r == 4'h0 |-> !dev_sda_oe)
    else $error("target drove sda in read ack slot");
endmodule : eeprom_link_monitor

// >>> verification/testbench.sv
// bench: controller and target joined across the link, user side driven here
// assumes a short write-cycle timer so acknowledge polling ends quickly
`timescale 1ns/1ps
module testbench;
  localparam int twr = 600;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [10:0] cmd_addr = 11'h000;
  logic [4:0] cmd_len = 5'h01;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b1;
  logic cmd_ready, wr_ready, rd_valid, done, nack, write_busy;
  logic [7:0] rd_data;
  logic [10:0] word_ptr;
  logic [7:0] wbuf [16];
  logic [7:0] rbuf [$];
  int num_errors = 0;
  int checks_done = 0;
  eeprom_link_if link ();
  eeprom_controller u_eeprom_controller (.clk(clk), .arst_n(arst_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .done(done), .nack(nack));
  eeprom_target #(.twr_cycles(twr)) u_eeprom_target (.clk(clk), .arst_n(arst_n), .link(link),
    .write_busy(write_busy), .word_ptr(word_ptr));
  eeprom_link_monitor #(.twr_cycles(twr)) u_eeprom_link_monitor (.clk(clk), .arst_n(arst_n), .scl(link.scl),
    .sda(link.sda), .ctl_sda_oe(link.ctl_sda_oe), .dev_sda_oe(link.dev_sda_oe), .write_busy(write_busy));
  always #2.5 clk = ~clk;
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one command; rd_ready held low for the first stall cycles
  task automatic do_cmd(input logic rd, input logic [10:0] addr, input logic [4:0] len, input int stall,
                        output logic nk);
    int n;
    int t;
    logic take;
    logic go;
    n = 0;
    rbuf.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= addr;
    cmd_len <= len;
    wr_valid <= !rd;
    wr_data <= wbuf[0];
    rd_ready <= (stall == 0);
    for (t = 0; t < 40000; t++) begin
      @(negedge clk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) rbuf.push_back(rd_data);
      if (t == stall && stall > 0) check("scl held while full", 11'h000, 11'(link.scl));
      if (done === 1'b1) break;
      take = wr_valid && wr_ready;
      go = cmd_valid && cmd_ready;
      @(posedge clk);
      if (go) cmd_valid <= 1'b0;
      if (take) begin
        n++;
        wr_data <= wbuf[n % 16];
      end
      if (t == stall) rd_ready <= 1'b1;
    end
    if (t == 40000) begin
      num_errors++;
      test_done();
    end
    nk = nack;
    @(posedge clk);
    wr_valid <= 1'b0;
    @(negedge clk);
  endtask : do_cmd
  // retry a read until the target answers again after its write cycle
  task automatic poll_read(input logic [10:0] addr, input logic [4:0] len, input int stall);
    logic nk;
    int p;
    p = 0;
    do begin
      do_cmd(1'b1, addr, len, stall, nk);
      if (p == 0) check("first poll refused", 11'h001, 11'(nk));
      p++;
    end while (nk && p < 50);
    check("poll answered", 11'h000, 11'(nk));
  endtask : poll_read
  task automatic scen_page_wrap();
    logic nk;
    int j;
    do_cmd(1'b0, 11'h1F5, 5'h10, 0, nk);
    check("page write nack", 11'h000, 11'(nk));
    check("busy after stop", 11'h001, 11'(write_busy));
    check("ptr stays in page", 11'h1F5, word_ptr);
    poll_read(11'h1F0, 5'h10, 0);
    check("read count", 11'h010, 11'(rbuf.size()));
    for (j = 0; j < 16 && j < rbuf.size(); j++) begin
      check("page data", 11'(wbuf[(j + 11) % 16]), 11'(rbuf[j]));
    end
    check("ptr wraps array", 11'h000, word_ptr);
  endtask : scen_page_wrap
  task automatic scen_read_wrap();
    logic nk;
    do_cmd(1'b0, 11'h001, 5'h00, 0, nk);
    check("byte write nack", 11'h000, 11'(nk));
    poll_read(11'h1FE, 5'h04, 3000);
    check("read count", 11'h004, 11'(rbuf.size()));
    if (rbuf.size() == 4) begin
      check("end byte 0", 11'(wbuf[9]), 11'(rbuf[0]));
      check("end byte 1", 11'(wbuf[10]), 11'(rbuf[1]));
      check("wrapped byte 0", 11'h000, 11'(rbuf[2]));
      check("wrapped byte 1", 11'(wbuf[0]), 11'(rbuf[3]));
    end
    check("ptr after read", 11'h002, word_ptr);
  endtask : scen_read_wrap
  initial begin
    int i;
    for (i = 0; i < 16; i++) wbuf[i] = 8'hA0 + 8'(i);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    scen_page_wrap();
    scen_read_wrap();
    test_done();
  end
endmodule : testbench
